// File: src/vrpd_pkg.sv
// Purpose: Shared constants for the verify, recalibrate and password-disable command block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Count, sector and cylinder registers keep a current and a previous byte each

package vrpd_pkg;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] VRPD_OFS_DATA     = 8'h00;
  localparam logic [7:0] VRPD_OFS_SECCNT   = 8'h04;
  localparam logic [7:0] VRPD_OFS_SECNUM   = 8'h08;
  localparam logic [7:0] VRPD_OFS_CYLLO    = 8'h0C;
  localparam logic [7:0] VRPD_OFS_CYLHI    = 8'h10;
  localparam logic [7:0] VRPD_OFS_DEVCTL   = 8'h14;
  localparam logic [7:0] VRPD_OFS_CMDSTAT  = 8'h18;
  localparam logic [7:0] VRPD_OFS_ERROR    = 8'h1C;
  localparam logic [7:0] VRPD_OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] VRPD_OFS_IRQ_CLR  = 8'h24;
  localparam logic [7:0] VRPD_OFS_IRQ_EN   = 8'h28;
  localparam logic [7:0] VRPD_OFS_SEC_CTRL = 8'h2C;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int VRPD_DEVCTL_HOB  = 7;
  localparam int VRPD_ERR_UNC     = 6;
  localparam int VRPD_ERR_IDN     = 4;
  localparam int VRPD_ERR_ABT     = 2;
  localparam int VRPD_ERR_TON     = 1;
  localparam int VRPD_ST_BSY      = 7;
  localparam int VRPD_ST_RDY      = 6;
  localparam int VRPD_ST_DSC      = 4;
  localparam int VRPD_ST_DRQ      = 3;
  localparam int VRPD_ST_ERR      = 0;
  localparam int VRPD_IRQ_DONE    = 0;
  localparam int VRPD_IRQ_FAIL    = 1;
  localparam int VRPD_PWD_ID_BIT  = 0;

  // ************************************************************
  // Opcodes, reset values and counts
  // ************************************************************
  localparam logic [7:0]  VRPD_OP_VERIFY_EXT = 8'h42;
  localparam logic [3:0]  VRPD_OP_RECAL_HI   = 4'h1;
  localparam logic [7:0]  VRPD_OP_PWD_DIS    = 8'hF6;
  localparam logic [7:0]  VRPD_RST_BYTE      = 8'h00;
  localparam logic [1:0]  VRPD_RST_IRQ       = 2'h0;
  localparam logic        VRPD_RST_SEC_EN    = 1'b0;
  localparam logic [16:0] VRPD_CNT_ZERO_MAX  = 17'h1_0000;
  localparam logic [7:0]  VRPD_PWD_FIRST_WRD = 8'h01;
  localparam logic [7:0]  VRPD_PWD_LAST_WRD  = 8'h10;
  localparam logic [7:0]  VRPD_SECTOR_LAST   = 8'hFF;

endpackage : vrpd_pkg

// File: src/vrpd_top.sv
// Purpose: Command handling for extended verify, recalibrate and security disable password
// Assumes: Media, seek and password store logic run on pclk
// Notes:   Registers reached over APB; one wait state on every access
//
// Our own choices: the register offsets and register access over APB.

`timescale 1ns/1ps

module vrpd_top import vrpd_pkg::*; (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  output logic              irq,
  output logic              med_vfy_req,
  output logic      [47:0]  med_vfy_lba,
  input  wire logic         med_vfy_done,
  input  wire logic         med_vfy_unc,
  output logic              seek_req,
  input  wire logic         seek_done,
  input  wire logic         seek_trk0_ok,
  input  wire logic [255:0] user_pwd,
  input  wire logic [255:0] master_pwd,
  output logic              lock_active
);

  // ************************************************************
  // Types and state
  // ************************************************************
  typedef enum logic [6:0] {
    VRPD_IDLE     = 7'b000_0001,
    VRPD_VFY_REQ  = 7'b000_0010,
    VRPD_VFY_WAIT = 7'b000_0100,
    VRPD_SEEK_REQ = 7'b000_1000,
    VRPD_SEEK_WT  = 7'b001_0000,
    VRPD_PWD_RX   = 7'b010_0000,
    VRPD_PWD_CMP  = 7'b100_0000
  } vrpd_state_e;

  vrpd_state_e  state_r;
  logic [7:0]   cnt_cur_r, cnt_prev_r, num_cur_r, num_prev_r;
  logic [7:0]   cyl_lo_cur_r, cyl_lo_prev_r, cyl_hi_cur_r, cyl_hi_prev_r;
  logic         hob_r;
  logic [7:0]   err_r;
  logic         err_st_r;
  logic [1:0]   irq_stat_r, irq_en_r;
  logic         sec_en_r;
  logic [47:0]  lba_r;
  logic [16:0]  rem_r;
  logic [7:0]   wcnt_r;
  logic         pwd_id_r;
  logic [255:0] pwd_buf_r;
  logic         wr_acc, rd_acc, mapped;
  logic         cmd_wr, data_wr;
  logic         fin_ok, fin_fail;
  logic         pwd_match;
  logic [7:0]   status;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // Password words must fill the stored password exactly
  if ((VRPD_PWD_LAST_WRD - VRPD_PWD_FIRST_WRD + 8'h01) * 16 != $bits(user_pwd)) begin : g_pwd_width_chk
    $error("password word range does not fit the stored password width");
  end

  // Password field must lie inside one sector
  if (VRPD_PWD_LAST_WRD >= VRPD_SECTOR_LAST) begin : g_sector_len_chk
    $error("password field does not fit inside one sector");
  end

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic [7:0] hob_sel(input logic hob, input logic [7:0] cur, input logic [7:0] prev);
    hob_sel = hob ? prev : cur;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a <= VRPD_OFS_SEC_CTRL) && (a[1:0] == 2'b00);
  endfunction

  assign wr_acc  = psel && penable && !pready && pwrite;
  assign rd_acc  = psel && penable && !pready && !pwrite;
  assign mapped  = is_mapped(paddr);
  assign cmd_wr  = wr_acc && (paddr == VRPD_OFS_CMDSTAT) && (state_r == VRPD_IDLE);
  assign data_wr = wr_acc && (paddr == VRPD_OFS_DATA) && (state_r == VRPD_PWD_RX);

  // Stored password picked by identifier only
  assign pwd_match = pwd_id_r ? (pwd_buf_r == master_pwd) : (pwd_buf_r == user_pwd);

  assign status = {(state_r != VRPD_IDLE) && (state_r != VRPD_PWD_RX), 1'b1, 1'b0,
                   state_r == VRPD_IDLE, state_r == VRPD_PWD_RX, 2'b00, err_st_r};

  // Completion events from the command engine
  always_comb begin
    fin_ok   = 1'b0;
    fin_fail = 1'b0;
    case (state_r)
      VRPD_VFY_WAIT: begin
        if (med_vfy_done) begin
          fin_fail = med_vfy_unc;
          fin_ok   = !med_vfy_unc && (rem_r == 17'h0_0001);
        end
      end
      VRPD_SEEK_WT: begin
        fin_ok   = seek_done && seek_trk0_ok;
        fin_fail = seek_done && !seek_trk0_ok;
      end
      VRPD_PWD_CMP: begin
        fin_fail = (!sec_en_r && !pwd_id_r) || !pwd_match;
        fin_ok   = !fin_fail;
      end
      VRPD_IDLE: begin
        fin_fail = cmd_wr && (pwdata[7:0] != VRPD_OP_VERIFY_EXT) && (pwdata[7:0] != VRPD_OP_PWD_DIS)
                   && (pwdata[7:4] != VRPD_OP_RECAL_HI);
      end
      default: begin
        fin_ok   = 1'b0;
        fin_fail = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // APB answer
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (rd_acc) begin
        case (paddr)
          VRPD_OFS_SECCNT:   prdata <= {24'h00_0000, hob_sel(hob_r, cnt_cur_r, cnt_prev_r)};
          VRPD_OFS_SECNUM:   prdata <= {24'h00_0000, hob_sel(hob_r, num_cur_r, num_prev_r)};
          VRPD_OFS_CYLLO:    prdata <= {24'h00_0000, hob_sel(hob_r, cyl_lo_cur_r, cyl_lo_prev_r)};
          VRPD_OFS_CYLHI:    prdata <= {24'h00_0000, hob_sel(hob_r, cyl_hi_cur_r, cyl_hi_prev_r)};
          VRPD_OFS_DEVCTL:   prdata <= {24'h00_0000, hob_r, 7'h00};
          VRPD_OFS_CMDSTAT:  prdata <= {24'h00_0000, status};
          VRPD_OFS_ERROR:    prdata <= {24'h00_0000, err_r};
          VRPD_OFS_IRQ_STAT: prdata <= {30'h000_0000, irq_stat_r};
          VRPD_OFS_IRQ_EN:   prdata <= {30'h000_0000, irq_en_r};
          VRPD_OFS_SEC_CTRL: prdata <= {31'h000_0000, sec_en_r};
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ************************************************************
  // Task-file registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_cur_r     <= VRPD_RST_BYTE;
      cnt_prev_r    <= VRPD_RST_BYTE;
      num_cur_r     <= VRPD_RST_BYTE;
      num_prev_r    <= VRPD_RST_BYTE;
      cyl_lo_cur_r  <= VRPD_RST_BYTE;
      cyl_lo_prev_r <= VRPD_RST_BYTE;
      cyl_hi_cur_r  <= VRPD_RST_BYTE;
      cyl_hi_prev_r <= VRPD_RST_BYTE;
      hob_r         <= 1'b0;
    end else if (state_r == VRPD_VFY_WAIT && med_vfy_done) begin
      if (med_vfy_unc) begin
        {num_prev_r, cyl_lo_prev_r, cyl_hi_prev_r} <= {lba_r[31:24], lba_r[39:32], lba_r[47:40]};
        {num_cur_r, cyl_lo_cur_r, cyl_hi_cur_r}    <= {lba_r[7:0], lba_r[15:8], lba_r[23:16]};
        {cnt_prev_r, cnt_cur_r}                    <= rem_r[15:0];
      end else if (rem_r == 17'h0_0001) begin
        {cnt_prev_r, cnt_cur_r} <= 16'h0000;
      end
    end else if (wr_acc && state_r == VRPD_IDLE) begin
      // Each count, sector or cylinder write pushes the current byte into the previous one
      case (paddr)
        VRPD_OFS_SECCNT: begin
          cnt_prev_r <= cnt_cur_r;
          cnt_cur_r  <= pwdata[7:0];
        end
        VRPD_OFS_SECNUM: begin
          num_prev_r <= num_cur_r;
          num_cur_r  <= pwdata[7:0];
        end
        VRPD_OFS_CYLLO: begin
          cyl_lo_prev_r <= cyl_lo_cur_r;
          cyl_lo_cur_r  <= pwdata[7:0];
        end
        VRPD_OFS_CYLHI: begin
          cyl_hi_prev_r <= cyl_hi_cur_r;
          cyl_hi_cur_r  <= pwdata[7:0];
        end
        VRPD_OFS_DEVCTL: hob_r <= pwdata[VRPD_DEVCTL_HOB];
        default: hob_r <= hob_r;
      endcase
    end
  end

  // ************************************************************
  // Command engine
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= VRPD_IDLE;
      lba_r       <= 48'h0000_0000_0000;
      rem_r       <= 17'h0_0000;
      med_vfy_req <= 1'b0;
      med_vfy_lba <= 48'h0000_0000_0000;
      seek_req    <= 1'b0;
    end else begin
      med_vfy_req <= 1'b0;
      seek_req    <= 1'b0;
      case (state_r)
        VRPD_IDLE: begin
          if (cmd_wr) begin
            if (pwdata[7:0] == VRPD_OP_VERIFY_EXT) begin
              lba_r   <= {cyl_hi_prev_r, cyl_lo_prev_r, num_prev_r,
                          cyl_hi_cur_r, cyl_lo_cur_r, num_cur_r};
              rem_r   <= ({cnt_prev_r, cnt_cur_r} == 16'h0000) ? VRPD_CNT_ZERO_MAX
                         : {1'b0, cnt_prev_r, cnt_cur_r};
              state_r <= VRPD_VFY_REQ;
            end else if (pwdata[7:4] == VRPD_OP_RECAL_HI) begin
              state_r <= VRPD_SEEK_REQ;
            end else if (pwdata[7:0] == VRPD_OP_PWD_DIS) begin
              state_r <= VRPD_PWD_RX;
            end
          end
        end
        VRPD_VFY_REQ: begin
          // Media check only; nothing is offered on the data port
          med_vfy_req <= 1'b1;
          med_vfy_lba <= lba_r;
          state_r     <= VRPD_VFY_WAIT;
        end
        VRPD_VFY_WAIT: begin
          if (med_vfy_done) begin
            if (med_vfy_unc || rem_r == 17'h0_0001) begin
              state_r <= VRPD_IDLE;
            end else begin
              lba_r   <= lba_r + 48'h0000_0000_0001;
              rem_r   <= rem_r - 17'h0_0001;
              state_r <= VRPD_VFY_REQ;
            end
          end
        end
        VRPD_SEEK_REQ: begin
          seek_req <= 1'b1;
          state_r  <= VRPD_SEEK_WT;
        end
        VRPD_SEEK_WT: begin
          if (seek_done) begin
            state_r <= VRPD_IDLE;
          end
        end
        VRPD_PWD_RX: begin
          if (data_wr && wcnt_r == VRPD_SECTOR_LAST) begin
            state_r <= VRPD_PWD_CMP;
          end
        end
        VRPD_PWD_CMP: state_r <= VRPD_IDLE;
        default: state_r <= VRPD_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Password sector capture
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt_r    <= 8'h00;
      pwd_id_r  <= 1'b0;
      pwd_buf_r <= '0;
    end else if (cmd_wr) begin
      wcnt_r <= 8'h00;
    end else if (data_wr) begin
      wcnt_r <= wcnt_r + 8'h01;
      if (wcnt_r == 8'h00) begin
        pwd_id_r <= pwdata[VRPD_PWD_ID_BIT];
      end else if (wcnt_r >= VRPD_PWD_FIRST_WRD && wcnt_r <= VRPD_PWD_LAST_WRD) begin
        // First byte of the password sits in the low byte of word 1
        pwd_buf_r[(wcnt_r - VRPD_PWD_FIRST_WRD) * 16 +: 16] <= pwdata[15:0];
      end
    end
  end

  // ************************************************************
  // Error, status and lock state
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r    <= VRPD_RST_BYTE;
      err_st_r <= 1'b0;
    end else if (cmd_wr) begin
      err_r    <= VRPD_RST_BYTE;
      err_st_r <= fin_fail;
      err_r[VRPD_ERR_ABT] <= fin_fail;
    end else if (fin_fail) begin
      err_st_r <= 1'b1;
      case (state_r)
        VRPD_VFY_WAIT: err_r[VRPD_ERR_UNC] <= 1'b1;
        VRPD_SEEK_WT:  err_r[VRPD_ERR_TON] <= 1'b1;
        default:       err_r[VRPD_ERR_ABT] <= 1'b1;
      endcase
    end
  end

  // Only the lock flag changes; stored passwords are never written here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_en_r <= VRPD_RST_SEC_EN;
    end else if (state_r == VRPD_PWD_CMP && fin_ok) begin
      sec_en_r <= 1'b0;
    end else if (wr_acc && paddr == VRPD_OFS_SEC_CTRL) begin
      sec_en_r <= pwdata[0];
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= VRPD_RST_IRQ;
      irq_en_r   <= VRPD_RST_IRQ;
    end else begin
      // Set wins over a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~((wr_acc && paddr == VRPD_OFS_IRQ_CLR) ? pwdata[1:0] : 2'b00))
                    | {fin_fail, fin_ok};
      if (wr_acc && paddr == VRPD_OFS_IRQ_EN) begin
        irq_en_r <= pwdata[1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq         <= 1'b0;
      lock_active <= 1'b0;
    end else begin
      irq         <= |(irq_stat_r & irq_en_r);
      lock_active <= sec_en_r;
    end
  end

endmodule // vrpd_top

// File: verification/vrpd_monitor.sv
// Purpose: Port checks for the verify, recalibrate and password block
// Assumes: One pclk domain, presetn async active low
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
module vrpd_monitor import vrpd_pkg::*; (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        med_vfy_req,
  input wire logic [47:0] med_vfy_lba,
  input wire logic        med_vfy_done,
  input wire logic        med_vfy_unc,
  input wire logic        seek_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        acc;
  logic        cmd_wr;
  logic [47:0] lba_r;
  logic        step_r;
  assign acc    = psel && penable && !pready;
  assign cmd_wr = acc && pwrite && paddr == VRPD_OFS_CMDSTAT;
  // ************************************************************
  // Last issued sector and whether it passed
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lba_r  <= '0;
      step_r <= 1'b0;
    end else begin
      if (med_vfy_req) lba_r <= med_vfy_lba;
      if (cmd_wr || med_vfy_req) step_r <= 1'b0;
      else if (med_vfy_done && !med_vfy_unc) step_r <= 1'b1;
    end
  end
  a_apb_one_wait: assert property (acc |=> pready) else $error("pready not one cycle after access");
  a_err_unmapped: assert property (acc && paddr > VRPD_OFS_SEC_CTRL |=> pready && pslverr)
    else $error("unmapped access without pslverr");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_vfy_start_req: assert property (cmd_wr && pwdata[7:0] == VRPD_OP_VERIFY_EXT |-> ##[1:3] med_vfy_req)
    else $error("verify command issued no sector request");
  a_vfy_req_pulse: assert property (med_vfy_req |=> !med_vfy_req) else $error("sector request too long");
  a_unc_stops_vfy: assert property (med_vfy_done && med_vfy_unc |=> !med_vfy_req [*4])
    else $error("sector request after uncorrectable error");
  a_lba_next_step: assert property (med_vfy_req && step_r |-> med_vfy_lba == lba_r + 48'h0000_0000_0001)
    else $error("next sector address wrong");
  a_recal_seek: assert property (cmd_wr && pwdata[7:4] == VRPD_OP_RECAL_HI |-> ##[1:3] seek_req)
    else $error("recalibrate issued no seek");
  a_seek_pulse: assert property (seek_req |=> !seek_req) else $error("seek request too long");
  c_vfy_unc: cover property (med_vfy_done && med_vfy_unc);
  c_seek: cover property (seek_req);
  c_slverr: cover property (pslverr);
endmodule // vrpd_monitor

// File: verification/vrpd_host_model.sv
// Purpose: Media and seek model on the far side of the block
// Assumes: One check per request, media answer 3 or 7 cycles and seek answer 5 cycles after the request pulse
// Notes:   Qualifier lines toggle outside their done pulse
`timescale 1ns/1ps
module vrpd_host_model (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        med_vfy_req,
  input wire logic [47:0] med_vfy_lba,
  input wire logic        seek_req,
  input wire logic [47:0] bad_lba,
  input wire logic        trk0_bad,
  output logic            med_vfy_done,
  output logic            med_vfy_unc,
  output logic            seek_done,
  output logic            seek_trk0_ok,
  output logic [31:0]     reqs
);
  logic [3:0]  wait_r;
  logic [2:0]  sk_r;
  logic        busy_r;
  logic        flip_r;
  logic [47:0] lba_r;
  // Outcome only valid with done
  assign med_vfy_unc  = med_vfy_done ? (lba_r == bad_lba) : flip_r;
  assign seek_trk0_ok = seek_done ? !trk0_bad : flip_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {wait_r, sk_r, busy_r, flip_r, lba_r, reqs, med_vfy_done, seek_done} <= '0;
    end else begin
      flip_r       <= ~flip_r;
      med_vfy_done <= 1'b0;
      seek_done    <= 1'b0;
      if (med_vfy_req) begin
        busy_r <= 1'b1;
        lba_r  <= med_vfy_lba;
        wait_r <= med_vfy_lba[0] ? 4'h5 : 4'h1;
        reqs   <= reqs + 32'h1;
      end else if (busy_r) begin
        if (wait_r == 4'h0) begin
          busy_r       <= 1'b0;
          med_vfy_done <= 1'b1;
        end else wait_r <= wait_r - 4'h1;
      end
      if (seek_req) sk_r <= 3'h4;
      else if (sk_r == 3'h1) seek_done <= 1'b1;
      if (!seek_req && sk_r != 3'h0) sk_r <= sk_r - 3'h1;
    end
  end
endmodule // vrpd_host_model

// File: verification/vrpd_bench.sv
// Purpose: Self-checking bench for verify, recalibrate and password commands
// Assumes: APB master with idle cycle between transfers
// Notes:   Stored passwords are fixed bench values
`timescale 1ns/1ps
module vrpd_bench import vrpd_pkg::*;;
  localparam logic [47:0]  L   = 48'h0A0B_0C0D_0E0F;
  localparam logic [255:0] UPW = {16{16'hA1B2}};
  localparam logic [255:0] MPW = {16{16'hC3D4}};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, slv, trk0_bad = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, reqs;
  logic [47:0] med_vfy_lba, bad_lba = '1;
  logic med_vfy_req, med_vfy_done, med_vfy_unc, seek_req, seek_done, seek_trk0_ok, lock_active;
  int err_count = 0, samples_checked = 0;
  always #4 pclk = ~pclk;
  vrpd_top u_vrpd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .med_vfy_req(med_vfy_req), .med_vfy_lba(med_vfy_lba), .med_vfy_done(med_vfy_done), .med_vfy_unc(med_vfy_unc),
    .seek_req(seek_req), .seek_done(seek_done), .seek_trk0_ok(seek_trk0_ok), .user_pwd(UPW), .master_pwd(MPW),
    .lock_active(lock_active));
  vrpd_host_model u_vrpd_host_model (.pclk(pclk), .presetn(presetn), .med_vfy_req(med_vfy_req),
    .med_vfy_lba(med_vfy_lba), .seek_req(seek_req), .bad_lba(bad_lba), .trk0_bad(trk0_bad),
    .med_vfy_done(med_vfy_done), .med_vfy_unc(med_vfy_unc), .seek_done(seek_done), .seek_trk0_ok(seek_trk0_ok),
    .reqs(reqs));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) err_count++;
  endtask
  task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0);
    check(nm, rd, exp);
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin apb(0, VRPD_OFS_CMDSTAT, 32'h0); n++; end
    while ((rd[VRPD_ST_BSY] !== 1'b0 || rd[VRPD_ST_DRQ] !== 1'b0) && n < 3000);
    if (n >= 3000) err_count++;
  endtask
  task automatic tf(input logic [15:0] c);
    apb(1, VRPD_OFS_SECCNT, {24'h0, c[15:8]});
    apb(1, VRPD_OFS_SECCNT, {24'h0, c[7:0]});
    for (int i = 0; i < 3; i++) begin
      apb(1, VRPD_OFS_SECNUM + 8'(4 * i), {24'h0, L[24 + 8 * i +: 8]});
      apb(1, VRPD_OFS_SECNUM + 8'(4 * i), {24'h0, L[8 * i +: 8]});
    end
  endtask
  task automatic vfy(input logic [15:0] c, input logic [47:0] b, input int nreq, input logic [15:0] left,
                     input logic [7:0] e);
    logic [31:0] r0;
    r0 = reqs;
    bad_lba <= b;
    tf(c);
    apb(1, VRPD_OFS_CMDSTAT, {24'h0, VRPD_OP_VERIFY_EXT});
    idle();
    check("status err", rd[VRPD_ST_ERR], e != 8'h0);
    check("requests", reqs - r0, nreq);
    chk("error", VRPD_OFS_ERROR, {24'h0, e});
    chk("count lo", VRPD_OFS_SECCNT, {24'h0, left[7:0]});
    apb(1, VRPD_OFS_DEVCTL, 32'h80);
    chk("count hi", VRPD_OFS_SECCNT, {24'h0, left[15:8]});
    apb(1, VRPD_OFS_DEVCTL, 32'h0);
  endtask
  task automatic pw(input logic id, input logic [255:0] k, input logic [7:0] e, input logic lk);
    apb(1, VRPD_OFS_CMDSTAT, {24'h0, VRPD_OP_PWD_DIS});
    apb(0, VRPD_OFS_CMDSTAT, 32'h0);
    check("bsy", rd[VRPD_ST_BSY], 0);
    check("drq", rd[VRPD_ST_DRQ], 1);
    for (int i = 0; i < 256; i++)
      apb(1, VRPD_OFS_DATA, i == 0 ? {31'h0, id} : i <= 16 ? {16'h0, k[(i - 1) * 16 +: 16]} : 32'h0);
    idle();
    chk("pwd error", VRPD_OFS_ERROR, {24'h0, e});
    check("lock", lock_active, lk);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ************************************************************
  // Watchdog
  // ************************************************************
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk("irq stat reset", VRPD_OFS_IRQ_STAT, 32'h0);
    chk("error reset", VRPD_OFS_ERROR, 32'h0);
    chk("unmapped", 8'h40, 32'h0);
    check("pslverr", slv, 1);
    apb(1, VRPD_OFS_IRQ_EN, 32'h3);
    vfy(16'h0002, '1, 2, 16'h0000, 8'h00);
    check("irq", irq, 1);
    chk("irq stat", VRPD_OFS_IRQ_STAT, 32'h1);
    apb(1, VRPD_OFS_IRQ_CLR, 32'h3);
    @(posedge pclk);
    check("irq clr", irq, 0);
    vfy(16'h0003, L + 48'h1, 2, 16'h0002, 8'h40);
    chk("irq stat fail", VRPD_OFS_IRQ_STAT, 32'h2);
    for (int h = 0; h < 2; h++) begin
      apb(1, VRPD_OFS_DEVCTL, {24'h0, h[0], 7'h0});
      for (int i = 0; i < 3; i++)
        chk("fail lba", VRPD_OFS_SECNUM + 8'(4 * i), {24'h0, 8'((L + 48'h1) >> (8 * i + 24 * h))});
    end
    apb(1, VRPD_OFS_DEVCTL, 32'h0);
    vfy(16'h0000, L + 48'h2, 3, 16'hFFFE, 8'h40);
    apb(1, VRPD_OFS_IRQ_CLR, 32'h3);
    apb(1, VRPD_OFS_IRQ_EN, 32'h0);
    for (int i = 0; i < 2; i++) begin
      trk0_bad <= i[0];
      apb(1, VRPD_OFS_CMDSTAT, i ? 32'h1F : 32'h10);
      idle();
      chk("recal error", VRPD_OFS_ERROR, i ? 32'h2 : 32'h0);
    end
    check("irq masked", irq, 0);
    chk("irq stat masked", VRPD_OFS_IRQ_STAT, 32'h3);
    apb(1, VRPD_OFS_CMDSTAT, 32'h0);
    chk("unknown op", VRPD_OFS_ERROR, 32'h4);
    apb(1, VRPD_OFS_SEC_CTRL, 32'h1);
    pw(1, UPW, 8'h04, 1);
    pw(0, UPW, 8'h00, 0);
    pw(0, UPW, 8'h04, 0);
    apb(1, VRPD_OFS_SEC_CTRL, 32'h1);
    pw(1, MPW, 8'h00, 0);
    finish_test();
  end
endmodule // vrpd_bench
bind vrpd_top vrpd_monitor u_vrpd_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .med_vfy_req(med_vfy_req),
  .med_vfy_lba(med_vfy_lba), .med_vfy_done(med_vfy_done), .med_vfy_unc(med_vfy_unc), .seek_req(seek_req));
